// ---- hw/reset_strap_capture.sv ----
// Reset strap capture: latches strap pins after reset release, then hands
// the pins back to their normal function and exposes the modes over APB.
// Assumes strap and APB inputs synchronous to ref_clk; pad ring applies pulls.
`timescale 1ns/1ps
`include "strap_cfg.svh"
module reset_strap_capture
  import strap_pkg::*;
#(
  parameter int CFG_W = 32
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // Strap pins, pad side
  input  wire logic [`STRAP_PINS-1:0]   strap_pin_in,
  output logic      [`STRAP_PINS-1:0]   strap_pin_out,
  output logic      [`STRAP_PINS-1:0]   strap_pin_oe_n,
  output logic      [`STRAP_PINS-1:0]   pull_up_en,
  output logic      [`STRAP_PINS-1:0]   pull_dn_en,
  output logic      [`STRAP_PINS-1:0]   pull_id0_only,
  // Normal pin function, core side
  input  wire logic [`STRAP_PINS-1:0]   func_data,
  input  wire logic [`STRAP_PINS-1:0]   func_drive,
  output logic      [`STRAP_PINS-1:0]   func_in,
  // Modes and configuration
  output strap_modes_s                  modes,
  output logic                          boot_from_eprom,
  output logic                          pins_functional,
  output logic      [CFG_W-1:0]         system_config_reg,
  output logic      [CFG_W-1:0]         sdram_config_reg
);

  // ----------------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------------
  localparam logic [2:0] REVERT_CYC = 3'(`STRAP_REVERT_CYC);

  strap_phase_e            phase_reg,  phase_next;
  logic [2:0]              wait_reg,   wait_next;
  logic [`STRAP_PINS-1:0]  straps_reg, straps_next;

  always_comb begin
    phase_next  = phase_reg;
    wait_next   = wait_reg;
    straps_next = straps_reg;
    case (phase_reg)
      PH_RESET: begin
        // First edge after release; a port cannot feed an async reset
        straps_next = strap_pin_in;
        wait_next   = REVERT_CYC;
        phase_next  = PH_LATCHED;
      end
      PH_LATCHED: begin
        if (wait_reg <= 3'h1) begin
          phase_next = PH_FUNCTIONAL;
        end else begin
          wait_next = wait_reg - 3'h1;
        end
      end
      PH_FUNCTIONAL: begin
        phase_next = PH_FUNCTIONAL;
      end
      default: begin
        phase_next = PH_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg  <= PH_RESET;
      wait_reg   <= 3'h0;
      straps_reg <= '0;
    end else begin
      phase_reg  <= phase_next;
      wait_reg   <= wait_next;
      straps_reg <= straps_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pad control
  // ----------------------------------------------------------------------
  logic [`STRAP_PINS-1:0] pin_out_next, pin_oe_n_next, pu_next, pd_next, func_in_next;
  logic                   functional_next;

  always_comb begin
    functional_next = (phase_next == PH_FUNCTIONAL);
    func_in_next    = strap_pin_in;
    // Pins stay undriven until the revert wait ends
    if (functional_next) begin
      pu_next       = `PULLUP_AFTER;
      pd_next       = `PULLDN_AFTER;
      pin_out_next  = func_data;
      pin_oe_n_next = ~(func_drive & `DRIVEN_AFTER);
    end else begin
      pu_next       = `PULLUP_IN_RESET;
      pd_next       = `PULLDN_IN_RESET;
      pin_out_next  = '0;
      pin_oe_n_next = '1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pull_up_en      <= `PULLUP_IN_RESET;
      pull_dn_en      <= `PULLDN_IN_RESET;
      pull_id0_only   <= `PULL_ID0_ONLY;
      strap_pin_out   <= '0;
      strap_pin_oe_n  <= '1;
      func_in         <= '0;
      pins_functional <= 1'b0;
    end else begin
      pull_up_en      <= pu_next;
      pull_dn_en      <= pd_next;
      pull_id0_only   <= `PULL_ID0_ONLY;
      strap_pin_out   <= pin_out_next;
      strap_pin_oe_n  <= pin_oe_n_next;
      func_in         <= func_in_next;
      pins_functional <= functional_next;
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  strap_modes_s modes_next;

  always_comb begin
    modes_next.boot_wait_external     = straps_next[`PIN_BOOT_SRC];
    modes_next.irq_lines_enabled      = straps_next[`PIN_IRQ_EN];
    modes_next.irq_level_sensitive    = straps_next[`PIN_IRQ_EN];
    modes_next.link_width_4bit        = straps_next[`PIN_LINK_WIDTH];
    modes_next.config_always_writable = straps_next[`PIN_CFG_PERMIT];
    // Test straps are only reported; the reset pull-ups keep them high
    modes_next.test_mode = straps_next[`PIN_TEST_C:`PIN_TEST_A];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modes           <= '0;
      boot_from_eprom <= 1'b0;
    end else begin
      modes           <= modes_next;
      // Held low in reset so nothing boots before the straps are known
      boot_from_eprom <= ~modes_next.boot_wait_external;
    end
  end

  // ----------------------------------------------------------------------
  // Write-once gates for the two configuration registers
  // ----------------------------------------------------------------------
  logic [1:0] cfg_wr_req, cfg_permit, cfg_written;

  for (genvar g = 0; g < 2; g++) begin : g_gate
    write_once_gate u_gate (
      .ref_clk         (ref_clk),
      .rstn            (rstn),
      .always_writable (modes.config_always_writable),
      .write_stb       (cfg_wr_req[g] & cfg_permit[g]),
      .permit          (cfg_permit[g]),
      .written         (cfg_written[g])
    );
  end

  // ----------------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------------
  logic             pready_next, pslverr_next, commit;
  logic [31:0]      prdata_next, status_word;
  logic [CFG_W-1:0] sys_next, sdram_next;
  logic             hit_status, hit_sys, hit_sdram;

  always_comb begin
    hit_status  = (paddr == `OFS_STRAP_STATUS);
    hit_sys     = (paddr == `OFS_SYS_CFG);
    hit_sdram   = (paddr == `OFS_SDRAM_CFG);
    commit      = psel & penable & pready;
    cfg_wr_req  = {commit & pwrite & hit_sdram, commit & pwrite & hit_sys};
    status_word = '0;
    status_word[`ST_STRAPS_LSB +: `STRAP_PINS] = straps_reg;
    status_word[`ST_PHASE_LSB +: 2]            = phase_reg;
    status_word[`ST_SYS_DONE]                  = cfg_written[0];
    status_word[`ST_SDRAM_DONE]                = cfg_written[1];
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    prdata_next  = '0;
    if (psel && penable && !pready) begin
      pready_next = 1'b1;
      if (hit_status) begin
        pslverr_next = pwrite;
        prdata_next  = status_word;
      end else if (hit_sys) begin
        // Refused writes flag an error and leave the register alone
        pslverr_next = pwrite & ~cfg_permit[0];
        prdata_next  = 32'(system_config_reg);
      end else if (hit_sdram) begin
        pslverr_next = pwrite & ~cfg_permit[1];
        prdata_next  = 32'(sdram_config_reg);
      end else begin
        pslverr_next = 1'b1;
      end
    end
    sys_next   = system_config_reg;
    sdram_next = sdram_config_reg;
    if (cfg_wr_req[0] && cfg_permit[0]) begin
      sys_next = pwdata[CFG_W-1:0];
    end
    if (cfg_wr_req[1] && cfg_permit[1]) begin
      sdram_next = pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      prdata            <= '0;
      system_config_reg <= CFG_W'(`SYS_CFG_RESET);
      sdram_config_reg  <= CFG_W'(`SDRAM_CFG_RESET);
    end else begin
      pready            <= pready_next;
      pslverr           <= pslverr_next;
      prdata            <= prdata_next;
      system_config_reg <= sys_next;
      sdram_config_reg  <= sdram_next;
    end
  end

endmodule

// ---- hw/strap_cfg.svh ----
// Constants for the reset strap capture block.
// Assumes a single 10 MHz clock and a 32-bit APB register port.
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define STRAP_REVERT_NS    400
`define STRAP_REVERT_CYC   ((`STRAP_REVERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Strap pin positions
// ----------------------------------------------------------------------
`define PIN_BOOT_SRC       0
`define PIN_IRQ_EN         1
`define PIN_LINK_WIDTH     2
`define PIN_CFG_PERMIT     3
`define PIN_TEST_A         4
`define PIN_TEST_B         5
`define PIN_TEST_C         6
`define STRAP_PINS         7

// ----------------------------------------------------------------------
// Pull and drive masks, bit per strap pin
// ----------------------------------------------------------------------
`define PULLUP_IN_RESET    7'h70
`define PULLDN_IN_RESET    7'h0f
`define PULLUP_AFTER       7'h09
`define PULLDN_AFTER       7'h00
`define PULL_ID0_ONLY      7'h09
`define DRIVEN_AFTER       7'h76

// ----------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------
`define OFS_STRAP_STATUS   12'h000
`define OFS_SYS_CFG        12'h004
`define OFS_SDRAM_CFG      12'h008
`define ST_STRAPS_LSB      0
`define ST_PHASE_LSB       8
`define ST_SYS_DONE        10
`define ST_SDRAM_DONE      11
`define SYS_CFG_RESET      32'h0000_0000
`define SDRAM_CFG_RESET    32'h0000_0000

`endif

// ---- hw/strap_pkg.sv ----
// Types shared by the strap capture block.
// Assumes strap_cfg.svh supplies the numeric constants.
package strap_pkg;

  // ----------------------------------------------------------------------
  // Capture phase
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_RESET      = 2'b00,
    PH_LATCHED    = 2'b01,
    PH_FUNCTIONAL = 2'b10
  } strap_phase_e;

  // ----------------------------------------------------------------------
  // Decoded operating modes
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       boot_wait_external;
    logic       irq_lines_enabled;
    logic       irq_level_sensitive;
    logic       link_width_4bit;
    logic       config_always_writable;
    logic [2:0] test_mode;
  } strap_modes_s;

endpackage

// ---- hw/write_once_gate.sv ----
// Write permission for one configuration register.
// Assumes write strobes arrive one cycle wide, in the ref_clk domain.
`timescale 1ns/1ps
module write_once_gate (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic always_writable,
  input  wire logic write_stb,
  output logic      permit,
  output logic      written
);

  logic written_reg;
  logic written_next;

  always_comb begin
    written_next = written_reg | write_stb;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      written_reg <= 1'b0;
    end else begin
      written_reg <= written_next;
    end
  end

  // One shot per reset unless the strap frees it
  assign permit  = always_writable | ~written_reg;
  assign written = written_reg;

endmodule

// ---- verif/reset_strap_capture_properties.sv ----
// Checker for the reset strap capture block.
// Assumes it is bound into reset_strap_capture; one clock domain.
`timescale 1ns/1ps
`include "strap_cfg.svh"
module strap_props
  import strap_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rstn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic [31:0]  prdata,
  input wire logic [6:0]   strap_pin_in,
  input wire logic [6:0]   strap_pin_out,
  input wire logic [6:0]   strap_pin_oe_n,
  input wire logic [6:0]   pull_up_en,
  input wire logic [6:0]   pull_dn_en,
  input wire logic [6:0]   pull_id0_only,
  input wire logic [6:0]   func_data,
  input wire logic [6:0]   func_drive,
  input wire logic [6:0]   func_in,
  input wire strap_modes_s modes,
  input wire logic         boot_from_eprom,
  input wire logic         pins_functional
);
  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic       up;
  logic [2:0] cnt;
  logic [6:0] s_q;
  // Counter saturates so long runs never wrap
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      up  <= 1'b0;
      cnt <= 3'h0;
    end else begin
      up  <= 1'b1;
      if (up && cnt != 3'h7) cnt <= cnt + 3'h1;
    end
  end
  always_ff @(posedge ref_clk) s_q <= strap_pin_in;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  strap_capture_a: assert property ((rstn && !up) |=>
    modes == {s_q[0], s_q[1], s_q[1], s_q[2], s_q[3], s_q[6:4]})
    else $error("modes differ from straps at release");
  modes_hold_a: assert property (up |=> $stable(modes))
    else $error("modes changed after capture");
  boot_select_a: assert property (boot_from_eprom == (up && !modes.boot_wait_external))
    else $error("boot select wrong");
  irq_pair_a: assert property (modes.irq_lines_enabled == modes.irq_level_sensitive)
    else $error("irq enable and level differ");
  pin_revert_a: assert property (pins_functional == (cnt >= 3'h4))
    else $error("pin revert time wrong");
  pull_state_a: assert property (pull_up_en == (pins_functional ? `PULLUP_AFTER :
    `PULLUP_IN_RESET) && pull_dn_en == (pins_functional ? `PULLDN_AFTER : `PULLDN_IN_RESET)
    && pull_id0_only == `PULL_ID0_ONLY) else $error("pull enables wrong");
  pad_idle_a: assert property (!pins_functional |-> strap_pin_oe_n == 7'h7f
    && strap_pin_out == 7'h00) else $error("pad driven before revert");
  pad_func_a: assert property (pins_functional |-> strap_pin_out == $past(func_data)
    && strap_pin_oe_n == ~($past(func_drive) & `DRIVEN_AFTER)) else $error("pad drive wrong");
  func_copy_a: assert property (up |-> func_in == $past(strap_pin_in))
    else $error("pad copy to core wrong");
  apb_wait_a: assert property ((psel && !penable) |=> !pready ##1 pready)
    else $error("apb wait state wrong");
  apb_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
endmodule
bind reset_strap_capture strap_props props (.*);

// ---- verif/reset_strap_capture_test.sv ----
// Self-checking bench for the reset strap capture block.
// Assumes strap_board resolves the pads; APB master on ref_clk.
`timescale 1ns/1ps
`include "strap_cfg.svh"
module reset_strap_capture_test;
  import strap_pkg::*;
  logic         ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic         boot_from_eprom, pins_functional;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, sys_q, sdr_q, rd, wv;
  logic [6:0]   pin_in, pin_out, oe_n, pu, pd;
  logic [3:0]   strap_hi, c;
  logic [6:0]   fdat = 7'h00;
  logic [6:0]   fdrv = 7'h7f;
  logic [3:0]   cfgs [4] = '{4'h0, 4'hf, 4'h5, 4'ha};
  strap_modes_s modes;
  int           errors, n_compared, cyc;
  reset_strap_capture dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .strap_pin_in(pin_in), .strap_pin_out(pin_out),
    .strap_pin_oe_n(oe_n), .pull_up_en(pu), .pull_dn_en(pd), .pull_id0_only(),
    .func_data(fdat), .func_drive(fdrv), .func_in(), .modes, .boot_from_eprom,
    .pins_functional, .system_config_reg(sys_q), .sdram_config_reg(sdr_q));
  strap_board board (.ref_clk, .strap_hi, .pad_out(pin_out), .pad_oe_n(oe_n),
    .pu_en(pu), .pd_en(pd), .pad_level(pin_in));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask
  // Leading edge keeps two transfers from driving psel in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic [3:0] s);
    @(posedge ref_clk);
    rstn <= 1'b0;
    strap_hi <= s;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    // Flip the straps right after the capture edge, while pulls still apply
    @(posedge ref_clk);
    strap_hi <= ~s;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic results;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Core side keeps changing so the pad path and late pin activity are real
  always @(posedge ref_clk) begin
    fdat <= fdat + 7'h13;
    fdrv <= fdat ^ 7'h2a;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, strap_hi} = '0;
    foreach (cfgs[k]) begin
      c = cfgs[k];
      rst(c);
      chk(32'(modes), 32'({c[0], c[1], c[1], c[2], c[3], 3'b111}));
      chk(32'(boot_from_eprom), 32'(!c[0]));
      for (int a = 4; a <= 8; a += 4) begin
        xfer(1'b1, 12'(a), 32'h1111 * a);
        chk(32'(err), 32'h0);
        xfer(1'b1, 12'(a), 32'h2222 * a);
        chk(32'(err), 32'(!c[3]));
        xfer(1'b0, 12'(a), 32'h0);
        wv = (c[3] ? 32'h2222 : 32'h1111) * a;
        chk(rd, wv);
        chk(a == 4 ? sys_q : sdr_q, wv);
      end
      strap_hi <= ~c;
      repeat (3) @(posedge ref_clk);
      chk(32'(modes), 32'({c[0], c[1], c[1], c[2], c[3], 3'b111}));
      xfer(1'b0, `OFS_STRAP_STATUS, 32'h0);
      chk(rd, {20'h0, 2'b11, 2'b10, 1'b0, 3'b111, c});
    end
    xfer(1'b1, 12'h00c, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    xfer(1'b0, 12'h00c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    xfer(1'b1, `OFS_STRAP_STATUS, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    results();
  end
endmodule

// ---- verif/strap_board.sv ----
// Board side of the strap pins: strong external straps and wire levels.
// Assumes device id 0, so the id-qualified pulls apply.
`timescale 1ns/1ps
module strap_board (
  input  wire logic       ref_clk,
  input  wire logic [3:0] strap_hi,
  input  wire logic [6:0] pad_out,
  input  wire logic [6:0] pad_oe_n,
  input  wire logic [6:0] pu_en,
  input  wire logic [6:0] pd_en,
  output logic      [6:0] pad_level
);
  logic [6:0] last = 7'h00;
  logic [6:0] ext;
  // Test straps get no external resistor
  assign ext = {3'b000, strap_hi};
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!pad_oe_n[i]) pad_level[i] = pad_out[i];
      else if (ext[i]) pad_level[i] = 1'b1;
      else if (pu_en[i]) pad_level[i] = 1'b1;
      else if (pd_en[i]) pad_level[i] = 1'b0;
      // Floating pad toggles so no stale level passes for a real one
      else pad_level[i] = ~last[i];
    end
  end
  always_ff @(posedge ref_clk) last <= pad_level;
endmodule
